/* File: src/hisr_pkg.sv */
// Purpose: Shared constants and types for the host interrupt status block.
// Assumes: APB register map with one aligned 32-bit word per register.
// Notes:   Bits 0 to 2 of the status byte belong to other logic and read zero here.
package hisr_pkg;

    // Register byte offsets on the APB bus.
    localparam logic [7:0] INT_STATUS_OFF = 8'h00;
    localparam logic [7:0] HOST_CTRL_OFF  = 8'h04;
    localparam logic [7:0] EVT_STATUS_OFF = 8'h08;
    localparam logic [7:0] EVT_MASK_OFF   = 8'h0C;

    // Host control register fields.
    localparam int CTRL_IRQ_EN_BIT = 0;
    localparam int CTRL_ASYNC_BIT  = 1;
    localparam logic [1:0] HOST_CTRL_RST = 2'h0;

    // Status byte field positions.
    localparam int NW_LSB    = 3;
    localparam int CMD_BIT   = 5;
    localparam int ASYNC_BIT = 6;
    localparam int FAULT_BIT = 7;

    // Non-wake-up FIFO condition codes.
    localparam logic [1:0] NW_NONE      = 2'h0;
    localparam logic [1:0] NW_IMMEDIATE = 2'h1;
    localparam logic [1:0] NW_LATENCY   = 2'h2;
    localparam logic [1:0] NW_WATERMARK = 2'h3;

    // Sticky event bits and their reset values.
    localparam int EVT_NW    = 0;
    localparam int EVT_STAT  = 1;
    localparam int EVT_FAULT = 2;
    localparam int EVT_INIT  = 3;
    localparam logic [3:0] EVT_RST  = 4'h0;
    localparam logic [3:0] MASK_RST = 4'h0;

    // Reset value of the reset-or-fault bit.
    localparam logic FAULT_RST = 1'b1;

    // Events from the non-wake-up FIFO.
    typedef struct packed {
        logic data;
        logic zero_lat_evt;
        logic lat_expired;
        logic watermark;
    } hisr_nw_evt_type;

    // Status byte layout.
    typedef struct packed {
        logic       fault;
        logic       async_data;
        logic       cmd_data;
        logic [1:0] nw;
        logic [2:0] other;
    } hisr_status_type;

    // Boot sequence phases.
    typedef enum logic [1:0] {
        BOOT_STRAP,
        BOOT_INIT,
        BOOT_RUN
    } hisr_boot_type;

endpackage

/* File: src/hisr_top.sv */
// Purpose: Builds the upper bits of the host interrupt status byte and the host IRQ.
// Assumes: All inputs are synchronous to CLK_I; FIFO flags are levels, events pulses.
// Notes:   Registers are reached over APB with zero wait states.
// Function
// - Bits 3-4 report non-wake-up FIFO condition.
// - Codes: none, immediate, latency, watermark.
// - Latency code needs expired latency, pending data.
// - Bit 5 flags command data, async clear.
// - Bit 6 flags async or debug data.
// - Async select moves command responses to bit 6.
// - Bit 7 set on fatal error.
// - Bit 7 set by reset, cleared after init.
// - No host IRQ until host configures it.
// - Watchdog or fatal reset may raise IRQ.
// - Reading a channel clears only its bits.
// - Host IRQ held until sources retrieved.
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/10ps
module hisr_top (
    // Clock and reset.
    input  wire logic                     CLK_I,
    input  wire logic                     RESET_N_I,
    // APB slave.
    input  wire logic                     PSEL_I,
    input  wire logic                     PENABLE_I,
    input  wire logic                     PWRITE_I,
    input  wire logic [7:0]               PADDR_I,
    input  wire logic [31:0]              PWDATA_I,
    output logic      [31:0]              PRDATA_O,
    output logic                          PREADY_O,
    output logic                          PSLVERR_O,
    // Non-wake-up FIFO events.
    input  wire hisr_pkg::hisr_nw_evt_type NW_EVT_I,
    input  wire logic                     RD_NW_I,
    // Status and debug FIFO content.
    input  wire logic                     STAT_CMD_DATA_I,
    input  wire logic                     STAT_DEBUG_DATA_I,
    input  wire logic                     RD_STAT_I,
    // Fault and boot.
    input  wire logic                     FATAL_ERR_I,
    input  wire logic                     INIT_DONE_I,
    input  wire logic                     WDOG_FATAL_RST_I,
    input  wire logic                     RETAINED_CFG_I,
    // Status and interrupts.
    output logic      [7:0]               INT_STATUS_O,
    output logic                          HOST_IRQ_O,
    output logic                          IRQ_O
);
    import hisr_pkg::*;

    // State registers.
    hisr_status_type status_q;
    hisr_status_type status_d;
    hisr_boot_type   boot_q;
    hisr_boot_type   boot_d;
    logic [1:0]      ctrl_q;
    logic [1:0]      ctrl_d;
    logic [3:0]      evt_q;
    logic [3:0]      evt_d;
    logic [3:0]      mask_q;
    logic [3:0]      mask_d;
    logic [31:0]     prdata_q;
    logic [31:0]     prdata_d;
    logic            host_irq_q;
    logic            host_irq_d;

    // Decode and strobes.
    logic            setup_rd;
    logic            acc_wr;
    logic            sel_status;
    logic            sel_ctrl;
    logic            sel_evt;
    logic            sel_mask;
    logic            mapped;
    logic            async_sel;
    logic            irq_en;

    // Status computation.
    logic [1:0]      nw_evt_code;
    logic [1:0]      nw_kept;
    logic            stat_rise;
    logic            pending;
    logic            strap_ok;
    logic [3:0]      evt_set;
    logic [3:0]      evt_clr;

    // Returns the higher-priority of two condition codes.
    function automatic logic [1:0] nw_max(input logic [1:0] a, input logic [1:0] b);
        nw_max = (a > b) ? a : b;
    endfunction

    // Zero-extends a 4-bit field to a bus word.
    function automatic logic [31:0] word4(input logic [3:0] v);
        word4 = {28'h0000000, v};
    endfunction

    // APB address decode; the slave always answers in the first access cycle.
    assign sel_status = (PADDR_I == INT_STATUS_OFF);
    assign sel_ctrl   = (PADDR_I == HOST_CTRL_OFF);
    assign sel_evt    = (PADDR_I == EVT_STATUS_OFF);
    assign sel_mask   = (PADDR_I == EVT_MASK_OFF);
    assign mapped     = sel_status | sel_ctrl | sel_evt | sel_mask;
    assign setup_rd   = PSEL_I & ~PENABLE_I & ~PWRITE_I;
    assign acc_wr     = PSEL_I & PENABLE_I & PWRITE_I & mapped;
    assign PREADY_O   = 1'b1;
    assign PSLVERR_O  = PSEL_I & PENABLE_I & ~mapped;
    assign PRDATA_O   = prdata_q;

    // Read data is sampled in the setup cycle so it comes from a flip-flop.
    // The cost is that a read shows the state one cycle before the access edge.
    assign prdata_d = !setup_rd   ? prdata_q :
                      sel_status  ? {24'h000000, status_q} :
                      sel_ctrl    ? {30'h00000000, ctrl_q} :
                      sel_evt     ? word4(evt_q) :
                      sel_mask    ? word4(mask_q) :
                                    32'h00000000;

    // Host control fields.
    assign async_sel = ctrl_q[CTRL_ASYNC_BIT];
    assign irq_en    = ctrl_q[CTRL_IRQ_EN_BIT];

    // Condition code of this cycle's events; watermark outranks latency and immediate.
    assign nw_evt_code = NW_EVT_I.watermark                       ? NW_WATERMARK :
                         (NW_EVT_I.lat_expired & NW_EVT_I.data)   ? NW_LATENCY   :
                         NW_EVT_I.zero_lat_evt                    ? NW_IMMEDIATE :
                                                                    NW_NONE;

    // A read of the non-wake-up channel drops the old code, a new event still lands.
    assign nw_kept = RD_NW_I ? NW_NONE : status_q.nw;

    // Next status byte; bits 5 and 6 mirror the status FIFO content.
    always_comb begin
        status_d            = status_q;
        status_d.other      = 3'h0;
        status_d.nw         = nw_max(nw_kept, nw_evt_code);
        status_d.cmd_data   = STAT_CMD_DATA_I & ~async_sel;
        status_d.async_data = STAT_DEBUG_DATA_I | (STAT_CMD_DATA_I & async_sel);
        if (FATAL_ERR_I) begin
            status_d.fault = 1'b1;
        end else if (INIT_DONE_I && boot_q == BOOT_INIT) begin
            status_d.fault = 1'b0;
        end
    end

    // Boot sequence: catch the retained setting just after reset release.
    always_comb begin
        boot_d = boot_q;
        case (boot_q)
            BOOT_STRAP: boot_d = BOOT_INIT;
            BOOT_INIT:  if (INIT_DONE_I) boot_d = BOOT_RUN;
            BOOT_RUN:   boot_d = BOOT_RUN;
            default:    boot_d = BOOT_STRAP;
        endcase
    end

    assign strap_ok = (boot_q == BOOT_STRAP) & WDOG_FATAL_RST_I & RETAINED_CFG_I;

    // Host control: off after reset unless the retained setting survives.
    always_comb begin
        ctrl_d = ctrl_q;
        if (strap_ok) begin
            ctrl_d[CTRL_IRQ_EN_BIT] = 1'b1;
        end
        if (acc_wr && sel_ctrl) begin
            ctrl_d = PWDATA_I[1:0];
        end
    end

    // Host IRQ follows any pending source in the status byte.
    assign pending    = (status_q.nw != NW_NONE) | status_q.cmd_data |
                        status_q.async_data | status_q.fault;
    assign host_irq_d = irq_en & pending;

    // Sticky events; a set in the clearing cycle wins.
    assign stat_rise = (status_d.cmd_data & ~status_q.cmd_data) |
                       (status_d.async_data & ~status_q.async_data);
    assign evt_set   = {INIT_DONE_I & (boot_q == BOOT_INIT),
                        FATAL_ERR_I,
                        stat_rise,
                        nw_evt_code != NW_NONE};
    assign evt_clr   = (acc_wr && sel_evt) ? PWDATA_I[3:0] : 4'h0;
    assign evt_d     = (evt_q & ~evt_clr) | evt_set;
    assign mask_d    = (acc_wr && sel_mask) ? PWDATA_I[3:0] : mask_q;
    assign IRQ_O     = |(evt_q & mask_q);

    // Status byte register; the bus write path never reaches it.
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            status_q       <= '0;
            status_q.fault <= FAULT_RST;
        end else begin
            status_q <= status_d;
        end
    end

    // Boot phase and host control registers.
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            boot_q <= BOOT_STRAP;
            ctrl_q <= HOST_CTRL_RST;
        end else begin
            boot_q <= boot_d;
            ctrl_q <= ctrl_d;
        end
    end

    // Event, mask, host IRQ and read data registers.
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            evt_q      <= EVT_RST;
            mask_q     <= MASK_RST;
            host_irq_q <= 1'b0;
            prdata_q   <= 32'h00000000;
        end else begin
            evt_q      <= evt_d;
            mask_q     <= mask_d;
            host_irq_q <= host_irq_d;
            prdata_q   <= prdata_d;
        end
    end

    assign INT_STATUS_O = status_q;
    assign HOST_IRQ_O   = host_irq_q;

    // Checks on the status byte and the host IRQ.
    a_nw_watermark_code: assert property (
        @(posedge CLK_I) disable iff (!RESET_N_I)
        NW_EVT_I.watermark |=> INT_STATUS_O[4:3] == 2'h3)
        else $error("Watermark did not give code 3.");

    a_nw_latency_gate: assert property (
        @(posedge CLK_I) disable iff (!RESET_N_I)
        (status_d.nw == NW_LATENCY && status_q.nw != NW_LATENCY)
        |-> (NW_EVT_I.lat_expired && NW_EVT_I.data))
        else $error("Latency code without expired latency and data.");

    a_nw_read_clear: assert property (
        @(posedge CLK_I) disable iff (!RESET_N_I)
        (RD_NW_I && nw_evt_code == NW_NONE) |=> INT_STATUS_O[4:3] == 2'h0)
        else $error("Non-wake-up read did not clear its field.");

    a_nw_other_read: assert property (
        @(posedge CLK_I) disable iff (!RESET_N_I)
        (RD_STAT_I && !RD_NW_I) |=> INT_STATUS_O[4:3] >= $past(INT_STATUS_O[4:3]))
        else $error("Status read disturbed the non-wake-up field.");

    a_cmd_bit_sync: assert property (
        @(posedge CLK_I) disable iff (!RESET_N_I)
        ##1 INT_STATUS_O[5] == $past(STAT_CMD_DATA_I && !async_sel))
        else $error("Command bit wrong for async select.");

    a_async_bit_route: assert property (
        @(posedge CLK_I) disable iff (!RESET_N_I)
        (STAT_CMD_DATA_I && async_sel) |=> (INT_STATUS_O[6] && !INT_STATUS_O[5]))
        else $error("Async command response not on bit 6.");

    a_fault_set: assert property (
        @(posedge CLK_I) disable iff (!RESET_N_I)
        FATAL_ERR_I |=> INT_STATUS_O[7])
        else $error("Fatal error did not set bit 7.");

    a_fault_after_reset: assert property (
        @(posedge CLK_I)
        $rose(RESET_N_I) |-> INT_STATUS_O[7] && boot_q == BOOT_STRAP)
        else $error("Bit 7 not set after reset.");

    a_fault_init_clear: assert property (
        @(posedge CLK_I) disable iff (!RESET_N_I)
        (INIT_DONE_I && !FATAL_ERR_I && boot_q == BOOT_INIT) |=> !INT_STATUS_O[7])
        else $error("Init done did not clear bit 7.");

    a_irq_needs_cfg: assert property (
        @(posedge CLK_I) disable iff (!RESET_N_I)
        HOST_IRQ_O |-> $past(irq_en))
        else $error("Host IRQ without configured type.");

    a_strap_irq: assert property (
        @(posedge CLK_I) disable iff (!RESET_N_I)
        (RESET_N_I && strap_ok) |=> ##1 HOST_IRQ_O)
        else $error("Retained setting did not raise host IRQ.");

    a_irq_hold: assert property (
        @(posedge CLK_I) disable iff (!RESET_N_I)
        $fell(HOST_IRQ_O) |-> $past(!pending || !irq_en))
        else $error("Host IRQ dropped with sources pending.");

    a_status_ro: assert property (
        @(posedge CLK_I) disable iff (!RESET_N_I)
        (acc_wr && sel_status) |=> ($stable(ctrl_q) && $stable(mask_q)))
        else $error("Write to status byte changed a register.");

endmodule

/* File: sim/hisr_host_model.sv */
// Purpose: Host processor model that reaches the status block registers over APB.
// Assumes: One clock; the slave may add wait states, so the model waits for pready.
// Notes:   The testbench calls the tasks of this model through its instance name.
`timescale 1ns/10ps
module hisr_host_model (
    // Clock.
    input  wire logic        clk_i,
    // APB master side.
    output logic             psel_o,
    output logic             penable_o,
    output logic             pwrite_o,
    output logic [7:0]       paddr_o,
    output logic [31:0]      pwdata_o,
    input  wire logic [31:0] prdata_i,
    input  wire logic        pready_i,
    input  wire logic        pslverr_i
);
    import hisr_pkg::*;

    // The bus is idle at time zero so that no request precedes the reset release.
    initial begin
        psel_o    = 1'b0;
        penable_o = 1'b0;
        pwrite_o  = 1'b0;
        paddr_o   = 8'h00;
        pwdata_o  = 32'h0000_0000;
    end

    // One transfer; it opens one edge late so a back-to-back call never reassigns in one step.
    task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                            output logic [31:0] rdata, output logic err);
        @(posedge clk_i);
        psel_o    <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o  <= wr;
        paddr_o   <= addr;
        pwdata_o  <= wdata;
        @(posedge clk_i);
        penable_o <= 1'b1;
        // The wait has no bound here; only the watchdog of the bench ends a hang.
        do @(posedge clk_i); while (pready_i !== 1'b1);
        rdata     = prdata_i;
        err       = pslverr_i;
        psel_o    <= 1'b0;
        penable_o <= 1'b0;
    endtask

    // The host sets the interrupt type before it relies on the line.
    task automatic host_enable_irq(input logic async_sel);
        logic [31:0] rd;
        logic        er;
        apb_xfer(1'b1, HOST_CTRL_OFF, 32'(async_sel) << CTRL_ASYNC_BIT | 32'h1, rd, er);
    endtask
endmodule

/* File: sim/tb_host_interrupt_status_reporting.sv */
// Purpose: Self-checking bench for the host interrupt status block.
// Assumes: Zero wait state APB slave; status outputs settle one edge after their cause.
// Notes:   Fault bit clears only once per boot, so the fatal scenario runs near the end.
`timescale 1ns/10ps
module tb_host_interrupt_status_reporting;
    import hisr_pkg::*;

    logic            clk = 1'b0;
    logic            rst_n = 1'b0;
    logic            psel, penable, pwrite, pready, pslverr, host_irq, irq, er;
    logic            rd_nw = 1'b0, rd_stat = 1'b0, cmd_d = 1'b0, dbg_d = 1'b0;
    logic            fatal = 1'b0, init_done = 1'b0, wdog = 1'b0, ret_cfg = 1'b0;
    logic [7:0]      paddr, int_status;
    logic [31:0]     pwdata, prdata, rd;
    hisr_nw_evt_type nw_evt = '0;
    int              err_count = 0;
    int              samples_checked = 0;

    // A 40 MHz clock.
    always #12.5 clk = ~clk;

    hisr_top u_dut (.CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .NW_EVT_I(nw_evt), .RD_NW_I(rd_nw),
        .STAT_CMD_DATA_I(cmd_d), .STAT_DEBUG_DATA_I(dbg_d), .RD_STAT_I(rd_stat),
        .FATAL_ERR_I(fatal), .INIT_DONE_I(init_done), .WDOG_FATAL_RST_I(wdog),
        .RETAINED_CFG_I(ret_cfg), .INT_STATUS_O(int_status), .HOST_IRQ_O(host_irq),
        .IRQ_O(irq));

    hisr_host_model u_host (.clk_i(clk), .psel_o(psel), .penable_o(penable),
        .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata),
        .pready_i(pready), .pslverr_i(pslverr));

    task automatic final_report;
        if (err_count == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_host.apb_xfer(1'b1, a, d, rd, er);
    endtask

    // Lets a cause land on the outputs, then samples away from the edge.
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic do_reset(input logic straps);
        @(posedge clk);
        rst_n   <= 1'b0;
        wdog    <= straps;
        ret_cfg <= straps;
        repeat (6) @(posedge clk);
        rst_n   <= 1'b1;
    endtask

    // Reset values, an unmapped read and a refused status write.
    task automatic t_reset;
        logic [7:0]  offs [4] = '{INT_STATUS_OFF, HOST_CTRL_OFF, EVT_STATUS_OFF, EVT_MASK_OFF};
        logic [31:0] exps [4] = '{32'h80, 32'h0, 32'h0, 32'h0};
        settle(0);
        check(32'(host_irq), 32'h0, "host irq after reset");
        check(32'(irq), 32'h0, "irq after reset");
        wr(INT_STATUS_OFF, 32'hFF);
        for (int i = 0; i < 4; i++) begin
            u_host.apb_xfer(1'b0, offs[i], 32'h0, rd, er);
            check(rd, exps[i], "register reset value");
        end
        u_host.apb_xfer(1'b0, 8'h10, 32'h0, rd, er);
        check({rd[30:0], er}, 32'h1, "unmapped read");
    endtask

    // The fault bit holds through boot and falls when init completes.
    task automatic t_boot;
        settle(3);
        check(32'(int_status), 32'h80, "fault bit during init");
        check(32'(host_irq), 32'h0, "host irq before setup");
        @(posedge clk);
        init_done <= 1'b1;
        @(posedge clk);
        init_done <= 1'b0;
        settle(0);
        check(32'(int_status), 32'h00, "fault bit after init");
    endtask

    // Every code, a refused latency without data, and read clearing per channel.
    task automatic t_nw;
        logic [3:0] stim [4] = '{4'b0010, 4'b1100, 4'b1010, 4'b1001};
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            nw_evt <= stim[i];
            @(posedge clk);
            nw_evt <= '0;
            settle(0);
            check(32'(int_status[4:3]), i, "fifo condition code");
            @(posedge clk);
            rd_stat <= 1'b1;
            @(posedge clk);
            rd_stat <= 1'b0;
            settle(1);
            check(32'(int_status[4:3]), i, "code after status read");
            @(posedge clk);
            rd_nw <= 1'b1;
            @(posedge clk);
            rd_nw <= 1'b0;
            settle(0);
            check(32'(int_status[4:3]), 32'h0, "code after fifo read");
        end
    endtask

    // Command data moves from bit 5 to bit 6 with the async select; debug data uses bit 6.
    task automatic t_stat;
        @(posedge clk);
        cmd_d <= 1'b1;
        settle(1);
        check(32'(int_status[6:5]), 32'h1, "command data sync");
        wr(HOST_CTRL_OFF, 32'h1 << CTRL_ASYNC_BIT);
        settle(1);
        check(32'(int_status[6:5]), 32'h2, "command data async");
        @(posedge clk);
        cmd_d <= 1'b0;
        dbg_d <= 1'b1;
        wr(HOST_CTRL_OFF, 32'h0);
        settle(1);
        check(32'(int_status[6:5]), 32'h2, "debug data");
        @(posedge clk);
        dbg_d <= 1'b0;
        settle(1);
        check(32'(int_status[6:5]), 32'h0, "status fifo empty");
    endtask

    // Event raised, masked, cleared; the host line holds until the fifo is read.
    task automatic t_irq;
        wr(EVT_STATUS_OFF, 32'hF);
        wr(EVT_MASK_OFF, 32'h1 << EVT_NW);
        u_host.host_enable_irq(1'b0);
        nw_evt <= 4'b1001;
        @(posedge clk);
        nw_evt <= '0;
        settle(1);
        check({30'h0, irq, host_irq}, 32'h3, "event raises both lines");
        wr(EVT_MASK_OFF, 32'h0);
        settle(0);
        check(32'(irq), 32'h0, "masked event");
        wr(EVT_MASK_OFF, 32'h1 << EVT_NW);
        wr(EVT_STATUS_OFF, 32'h1 << EVT_NW);
        u_host.apb_xfer(1'b0, EVT_STATUS_OFF, 32'h0, rd, er);
        settle(0);
        check({rd[30:0], irq}, 32'h0, "cleared event");
        check(32'(host_irq), 32'h1, "host line held until read");
        @(posedge clk);
        rd_nw <= 1'b1;
        @(posedge clk);
        rd_nw <= 1'b0;
        settle(1);
        check(32'(host_irq), 32'h0, "host line after read");
    endtask

    // A fatal error sets the fault bit; a watchdog reset with kept setup raises the line.
    task automatic t_fault;
        @(posedge clk);
        fatal <= 1'b1;
        @(posedge clk);
        fatal <= 1'b0;
        settle(0);
        check(32'(int_status[7]), 32'h1, "fault bit on fatal");
        do_reset(1'b1);
        settle(3);
        check(32'(host_irq), 32'h1, "host line after watchdog reset");
    endtask

    // Main sequence.
    initial begin
        do_reset(1'b0);
        t_reset;
        t_boot;
        t_nw;
        t_stat;
        t_irq;
        t_fault;
        final_report;
    end

    // The whole run takes well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        final_report;
    end
endmodule
